// ===== src/rdx_pkg.sv
// shared constants for the extended-address dma read command block
// Notes on behaviour
// RULE1: command code 25h selects extended dma read
// RULE2: accepted command reads sectors then delivers them
// RULE3: sector data leaves as 16-bit words
// RULE4: host arms dma before writing command
// RULE5: device request paces words, host moves them
// RULE6: one interrupt after data ends, status ready
// RULE7: uncorrectable sector stops transfer there
// RULE8: count low from current, high from previous
// RULE9: count zero means 65,536 sectors
// RULE10: current bytes lba 23:0, previous 47:24
// RULE11: error reads, select clear, give lba 23:0
// RULE12: error reads, select set, give lba 47:24
// RULE13: error byte: crc, unc, idnf, abort only
// RULE14: final status: busy, fault, corrected zero
// RULE15: act only when device select matches
// RULE16: busy from command until final status, irq
package rdx_pkg;
   // task-file register selects
   localparam logic [2:0] ADR_DATA   = 3'h0;
   localparam logic [2:0] ADR_ERROR  = 3'h1;
   localparam logic [2:0] ADR_COUNT  = 3'h2;
   localparam logic [2:0] ADR_SECTOR = 3'h3;
   localparam logic [2:0] ADR_CYL_LO = 3'h4;
   localparam logic [2:0] ADR_CYL_HI = 3'h5;
   localparam logic [2:0] ADR_DEVICE = 3'h6;
   localparam logic [2:0] ADR_CMD    = 3'h7;
   // command code and device/head layout
   localparam logic [7:0] CMD_READ_DMA_EXT = 8'h25;
   localparam int         DEV_SEL_BIT      = 4;
   localparam logic [2:0] DEV_HEAD_FIXED   = 3'h7;
   // error byte fields
   localparam int ERR_CRC = 7;
   localparam int ERR_UNC = 6;
   localparam int ERR_IDN = 4;
   localparam int ERR_ABT = 2;
   // status byte fields
   localparam int ST_BUSY = 7;
   localparam int ST_RDY  = 6;
   localparam int ST_DF   = 5;
   localparam int ST_DSC  = 4;
   localparam int ST_DRQ  = 3;
   localparam int ST_COR  = 2;
   localparam int ST_IDX  = 1;
   localparam int ST_ERR  = 0;
   // widths and reset values
   localparam int          LBA_W      = 48;
   localparam int          CNT_W      = 17;
   localparam logic [16:0] CNT_MAX    = 17'h10000;
   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam int          FIFO_DEPTH = 8;
endpackage

// ===== src/rdx_if.sv
// task-file register, dma and interrupt link between host and device
`timescale 1ns/1ps
interface rdx_if;
   logic        wr;     // host register write strobe
   logic        rd;     // host register read strobe
   logic [2:0]  addr;   // register select
   logic [7:0]  wdata;  // write byte
   logic        high_order_byte_select;    // high-order-byte select for reads
   logic        dmack;  // host dma acknowledge
   logic [7:0]  rdata;  // read byte
   logic        rvalid; // read byte valid, one cycle after rd
   logic        dmarq;  // device dma request, word on data
   logic [15:0] data;   // data word
   logic        intrq;  // device interrupt
   modport dev  (input wr, rd, addr, wdata, high_order_byte_select, dmack,
                 output rdata, rvalid, dmarq, data, intrq);
   modport host (output wr, rd, addr, wdata, high_order_byte_select, dmack,
                 input rdata, rvalid, dmarq, data, intrq);
endinterface

// ===== src/rdx_dev.sv
// device end: fifo and extended dma read command handler
`timescale 1ns/1ps
module rdx_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_resetn,
   // fill side
   input  wire logic                       i_in_valid,
   output logic                            o_in_ready,
   input  wire logic [W-1:0]               i_in_data,
   // drain side
   output logic                            o_out_valid,
   input  wire logic                       i_out_ready,
   output logic [W-1:0]                    o_out_data,
   // occupancy
   output logic [$clog2(DEPTH):0]          o_level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;
   logic         push;
   logic         pop;

   // extra pointer bit tells full from empty
   assign o_level     = wr_ptr - rd_ptr;
   assign o_in_ready  = (o_level != (AW+1)'(DEPTH));
   assign o_out_valid = (wr_ptr != rd_ptr);
   assign o_out_data  = mem[rd_ptr[AW-1:0]];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // storage
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= i_in_data;
   end

   // pointers
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

module rdx_dev #(
   parameter bit DEV_POS = 1'b0,
   parameter int DEPTH   = 8
) (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // link to host
   rdx_if.dev               link,
   // media side
   output logic             o_media_req,
   output logic [47:0]      o_media_lba,
   output logic             o_media_ready,
   input  wire logic        i_media_valid,
   input  wire logic [15:0] i_media_word,
   input  wire logic        i_media_last,
   input  wire logic        i_media_unc,
   input  wire logic        i_media_idnf
);
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_XFER  = 3'b010,
      S_DRAIN = 3'b100
   } rdx_state_t;

   rdx_state_t                 st;
   logic [7:0]                 cnt_cur, cnt_prev, sec_cur, sec_prev;
   logic [7:0]                 cl_cur, cl_prev, ch_cur, ch_prev;
   logic                       dev_bit;
   logic [rdx_pkg::LBA_W-1:0]  lba;
   logic [rdx_pkg::CNT_W-1:0]  remain;
   logic [7:0]                 err;
   logic                       busy;
   logic                       err_sum;
   logic                       fifo_in_valid, fifo_in_ready;
   logic                       fifo_out_valid, fifo_out_ready;
   logic [15:0]                fifo_out_data;
   logic [$clog2(DEPTH):0]     fifo_level;
   logic                       take;
   logic                       bad;
   logic                       end_now;
   logic                       cmd_hit;
   logic                       moved;
   logic                       drained;
   logic [7:0]                 status;

   // media word accepted only while transferring
   assign take    = i_media_valid && o_media_ready && (st == S_XFER);
   assign bad     = i_media_unc || i_media_idnf;
   assign end_now = take && (bad || (i_media_last && remain == rdx_pkg::CNT_W'(1)));
   assign fifo_in_valid  = take && !bad;
   assign fifo_out_ready = !link.dmarq || link.dmack;
   assign moved   = link.dmarq && link.dmack; // RULE5
   assign drained = !fifo_out_valid && (!link.dmarq || moved);
   // command takes effect only for our device position
   assign cmd_hit = link.wr && link.addr == rdx_pkg::ADR_CMD && !busy
                    && dev_bit == DEV_POS; // RULE15
   assign status  = {busy, 1'b1, 1'b0, 1'b1, 4'h0} | {7'h00, err_sum}; // RULE14

   rdx_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (i_media_word),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data),
      .o_level     (fifo_level)
   );

   // task-file writes: each count, sector or cylinder write pushes current into previous
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         {cnt_cur, cnt_prev, sec_cur, sec_prev} <= {4{rdx_pkg::REG_RESET}};
         {cl_cur, cl_prev, ch_cur, ch_prev}     <= {4{rdx_pkg::REG_RESET}};
         dev_bit <= 1'b0;
      end
      else if (link.wr && !busy)
      begin
         if (link.addr == rdx_pkg::ADR_COUNT)
            {cnt_prev, cnt_cur} <= {cnt_cur, link.wdata};
         else if (link.addr == rdx_pkg::ADR_SECTOR)
            {sec_prev, sec_cur} <= {sec_cur, link.wdata};
         else if (link.addr == rdx_pkg::ADR_CYL_LO)
            {cl_prev, cl_cur} <= {cl_cur, link.wdata};
         else if (link.addr == rdx_pkg::ADR_CYL_HI)
            {ch_prev, ch_cur} <= {ch_cur, link.wdata};
         else if (link.addr == rdx_pkg::ADR_DEVICE)
            dev_bit <= link.wdata[rdx_pkg::DEV_SEL_BIT];
      end
   end

   // command sequencer: fetch sectors, drain, post status
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st      <= S_IDLE;
         lba     <= '0;
         remain  <= '0;
         err     <= rdx_pkg::REG_RESET;
         busy    <= 1'b0;
         err_sum <= 1'b0;
      end
      else
      begin
         case (st)
            S_IDLE:
               if (cmd_hit && link.wdata == rdx_pkg::CMD_READ_DMA_EXT) // RULE1
               begin
                  st      <= S_XFER; // RULE2
                  busy    <= 1'b1; // RULE16
                  err     <= rdx_pkg::REG_RESET;
                  err_sum <= 1'b0;
                  lba     <= {ch_prev, cl_prev, sec_prev, ch_cur, cl_cur, sec_cur}; // RULE10
                  if ({cnt_prev, cnt_cur} == 16'h0000)
                     remain <= rdx_pkg::CNT_MAX; // RULE9
                  else
                     remain <= {1'b0, cnt_prev, cnt_cur}; // RULE8
               end
               else if (cmd_hit)
               begin
                  // unknown code: abort without any transfer
                  err     <= 8'h01 << rdx_pkg::ERR_ABT; // RULE13
                  err_sum <= 1'b1;
               end
            S_XFER:
               if (take && bad)
               begin
                  // lba stays on the failing sector for the host to read
                  err[rdx_pkg::ERR_UNC] <= i_media_unc; // RULE13
                  err[rdx_pkg::ERR_IDN] <= i_media_idnf;
                  st <= S_DRAIN; // RULE7
               end
               else if (take && i_media_last)
               begin
                  lba    <= lba + 1'b1;
                  remain <= remain - 1'b1;
                  if (end_now)
                     st <= S_DRAIN;
               end
            S_DRAIN:
               if (drained)
               begin
                  st      <= S_IDLE;
                  busy    <= 1'b0; // RULE16
                  err_sum <= (err != 8'h00); // RULE14
               end
            default:
               st <= S_IDLE;
         endcase
      end
   end

   // media request and back-pressure; two slots kept for words in flight
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_media_req   <= 1'b0;
         o_media_ready <= 1'b0;
         o_media_lba   <= '0;
      end
      else
      begin
         o_media_req   <= (st == S_XFER) && !end_now;
         o_media_ready <= (st == S_XFER) && !end_now && fifo_in_ready
                          && fifo_level < ($clog2(DEPTH)+1)'(DEPTH - 2);
         o_media_lba   <= lba;
      end
   end

   // dma word register: request held until the host acknowledges
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         link.dmarq <= 1'b0;
         link.data  <= 16'h0000;
      end
      else if (fifo_out_ready)
      begin
         link.dmarq <= fifo_out_valid; // RULE5
         if (fifo_out_valid)
            link.data <= fifo_out_data; // RULE3
      end
   end

   // single completion interrupt; a new interrupt beats the clearing read
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         link.intrq <= 1'b0;
      else if ((st == S_DRAIN && drained) || (st == S_IDLE && cmd_hit
               && link.wdata != rdx_pkg::CMD_READ_DMA_EXT))
         link.intrq <= 1'b1; // RULE6
      else if ((link.rd && link.addr == rdx_pkg::ADR_CMD) || cmd_hit)
         link.intrq <= 1'b0;
   end

   // register reads answer one cycle later
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         link.rvalid <= 1'b0;
         link.rdata  <= rdx_pkg::REG_RESET;
      end
      else
      begin
         link.rvalid <= link.rd;
         if (!link.rd)
            link.rdata <= rdx_pkg::REG_RESET;
         else if (link.addr == rdx_pkg::ADR_ERROR)
            link.rdata <= err;
         else if (link.addr == rdx_pkg::ADR_COUNT)
            link.rdata <= link.high_order_byte_select ? remain[15:8] : remain[7:0];
         else if (link.addr == rdx_pkg::ADR_SECTOR)
            link.rdata <= link.high_order_byte_select ? lba[31:24] : lba[7:0]; // RULE11 RULE12
         else if (link.addr == rdx_pkg::ADR_CYL_LO)
            link.rdata <= link.high_order_byte_select ? lba[39:32] : lba[15:8]; // RULE11 RULE12
         else if (link.addr == rdx_pkg::ADR_CYL_HI)
            link.rdata <= link.high_order_byte_select ? lba[47:40] : lba[23:16]; // RULE11 RULE12
         else if (link.addr == rdx_pkg::ADR_CMD)
            link.rdata <= status;
         else
            link.rdata <= rdx_pkg::REG_RESET;
      end
   end
endmodule

// ===== src/rdx_host.sv
// host end: programs the command, runs slave dma, reads final status
`timescale 1ns/1ps
module rdx_host (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // link to device
   rdx_if.host              link,
   // user request
   input  wire logic        i_start,
   input  wire logic [47:0] i_lba,
   input  wire logic [15:0] i_count,
   input  wire logic        i_dev_sel,
   // user answer
   output logic             o_word_valid,
   output logic [15:0]      o_word,
   output logic             o_done,
   output logic             o_busy,
   output logic [7:0]       o_status,
   output logic [7:0]       o_error,
   output logic [47:0]      o_err_lba
);
   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_WRITE = 4'b0010,
      H_WAIT  = 4'b0100,
      H_READ  = 4'b1000
   } rdx_hstate_t;

   rdx_hstate_t  st;
   logic [3:0]   step;
   logic         armed;
   logic [47:0]  lba_q;
   logic [15:0]  cnt_q;
   logic         dev_q;
   logic [2:0]   wr_addr;
   logic [7:0]   wr_data;
   logic [2:0]   rd_addr;

   // write order: previous byte then current byte of each pair
   always_comb
   begin
      wr_addr = rdx_pkg::ADR_CMD;
      wr_data = rdx_pkg::CMD_READ_DMA_EXT; // RULE1
      case (step)
         4'h0: {wr_addr, wr_data} = {rdx_pkg::ADR_COUNT, cnt_q[15:8]}; // RULE8
         4'h1: {wr_addr, wr_data} = {rdx_pkg::ADR_COUNT, cnt_q[7:0]};
         4'h2: {wr_addr, wr_data} = {rdx_pkg::ADR_SECTOR, lba_q[31:24]}; // RULE10
         4'h3: {wr_addr, wr_data} = {rdx_pkg::ADR_SECTOR, lba_q[7:0]};
         4'h4: {wr_addr, wr_data} = {rdx_pkg::ADR_CYL_LO, lba_q[39:32]};
         4'h5: {wr_addr, wr_data} = {rdx_pkg::ADR_CYL_LO, lba_q[15:8]};
         4'h6: {wr_addr, wr_data} = {rdx_pkg::ADR_CYL_HI, lba_q[47:40]};
         4'h7: {wr_addr, wr_data} = {rdx_pkg::ADR_CYL_HI, lba_q[23:16]};
         4'h8: {wr_addr, wr_data} = {rdx_pkg::ADR_DEVICE,
                                     {rdx_pkg::DEV_HEAD_FIXED, dev_q, 4'h0}};
         default: ;
      endcase
   end

   // read order: status, error, low address bytes, high address bytes
   always_comb
   begin
      rd_addr = rdx_pkg::ADR_CMD;
      if (step == 4'h1)
         rd_addr = rdx_pkg::ADR_ERROR;
      else if (step == 4'h2 || step == 4'h5)
         rd_addr = rdx_pkg::ADR_SECTOR;
      else if (step == 4'h3 || step == 4'h6)
         rd_addr = rdx_pkg::ADR_CYL_LO;
      else if (step == 4'h4 || step == 4'h7)
         rd_addr = rdx_pkg::ADR_CYL_HI;
   end

   // sequencer and register strobes
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st         <= H_IDLE;
         step       <= 4'h0;
         armed      <= 1'b0;
         lba_q      <= '0;
         cnt_q      <= 16'h0000;
         dev_q      <= 1'b0;
         link.wr    <= 1'b0;
         link.rd    <= 1'b0;
         link.addr  <= 3'h0;
         link.wdata <= 8'h00;
         link.high_order_byte_select   <= 1'b0;
         o_done     <= 1'b0;
         o_busy     <= 1'b0;
      end
      else
      begin
         link.wr <= 1'b0;
         link.rd <= 1'b0;
         o_done  <= 1'b0;
         case (st)
            H_IDLE:
               if (i_start)
               begin
                  lba_q  <= i_lba;
                  cnt_q  <= i_count;
                  dev_q  <= i_dev_sel;
                  armed  <= 1'b1; // RULE4
                  o_busy <= 1'b1;
                  step   <= 4'h0;
                  st     <= H_WRITE;
               end
            H_WRITE:
            begin
               link.wr    <= 1'b1;
               link.addr  <= wr_addr;
               link.wdata <= wr_data;
               step       <= step + 1'b1;
               if (step == 4'h9)
               begin
                  step <= 4'h0;
                  st   <= H_WAIT;
               end
            end
            H_WAIT:
               if (link.intrq)
               begin
                  armed <= 1'b0;
                  st    <= H_READ;
               end
            H_READ:
               if (!link.rd && !link.rvalid)
               begin
                  link.rd   <= 1'b1;
                  link.addr <= rd_addr;
                  link.high_order_byte_select  <= (step >= 4'h5);
               end
               else if (link.rvalid)
               begin
                  step <= step + 1'b1;
                  if (step == 4'h7)
                  begin
                     st       <= H_IDLE;
                     o_busy   <= 1'b0;
                     o_done   <= 1'b1;
                     link.high_order_byte_select <= 1'b0;
                  end
               end
            default:
               st <= H_IDLE;
         endcase
      end
   end

   // captured answers
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_status  <= 8'h00;
         o_error   <= 8'h00;
         o_err_lba <= '0;
      end
      else if (st == H_READ && link.rvalid)
      begin
         case (step)
            4'h0: o_status          <= link.rdata;
            4'h1: o_error           <= link.rdata;
            4'h2: o_err_lba[7:0]    <= link.rdata;
            4'h3: o_err_lba[15:8]   <= link.rdata;
            4'h4: o_err_lba[23:16]  <= link.rdata;
            4'h5: o_err_lba[31:24]  <= link.rdata;
            4'h6: o_err_lba[39:32]  <= link.rdata;
            4'h7: o_err_lba[47:40]  <= link.rdata;
            default: ;
         endcase
      end
   end

   // slave dma: acknowledge every other cycle, word moves on request and ack
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         link.dmack   <= 1'b0;
         o_word_valid <= 1'b0;
         o_word       <= 16'h0000;
      end
      else
      begin
         link.dmack   <= armed && link.dmarq && !link.dmack; // RULE5
         o_word_valid <= link.dmarq && link.dmack;
         if (link.dmarq && link.dmack)
            o_word <= link.data; // RULE3
      end
   end
endmodule

// ===== tb/rdx_props.sv
// concurrent checks on the link between the host and device ends
`timescale 1ns/1ps
module rdx_props (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // link signals
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        dmack,
   input  wire logic [7:0]  rdata,
   input  wire logic        rvalid,
   input  wire logic        dmarq,
   input  wire logic [15:0] data,
   input  wire logic        intrq
);
   logic armed;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   // armed by a read command write, dropped once the interrupt is up
   always_ff @(posedge i_ref_clk or negedge i_resetn)
      if (!i_resetn)
         armed <= 1'b0;
      else if (wr && addr == rdx_pkg::ADR_CMD && wdata == rdx_pkg::CMD_READ_DMA_EXT)
         armed <= 1'b1;
      else if (intrq)
         armed <= 1'b0;
   sequence s_status_read;
      rd && addr == rdx_pkg::ADR_CMD && intrq;
   endsequence
   // busy, fault, corrected low; ready and seek complete high
   sequence s_clean_status;
      rvalid && (rdata & 8'hf4) == 8'h50;
   endsequence
   a_final_status: assert property (s_status_read |=> s_clean_status)
      else $error("final status flags wrong");
   a_read_answer: assert property (rd |=> rvalid)
      else $error("read not answered next cycle");
   a_error_zeros: assert property (rd && addr == rdx_pkg::ADR_ERROR |=>
      (rdata & 8'h2b) == 8'h00)
      else $error("error byte has a reserved bit set");
   a_word_held: assert property (dmarq && !dmack |=> dmarq && $stable(data))
      else $error("dma word changed before it moved");
   a_ack_on_req: assert property (dmack |-> dmarq)
      else $error("dma acknowledge without request");
   a_irq_after_data: assert property (intrq |-> !dmarq)
      else $error("interrupt while data still moving");
   a_one_irq: assert property ($rose(intrq) |-> armed)
      else $error("second interrupt for one command");
   a_dma_after_cmd: assert property (dmarq |-> armed)
      else $error("dma request without a read command");
endmodule

// ===== tb/rdx_tb_top.sv
// bench joining host and device ends, with a media source and checks
`timescale 1ns/1ps
module rdx_tb_top;
   localparam int TMO = 40000;
   logic        i_ref_clk;
   logic        i_resetn;
   logic        start;
   logic        dev_sel;
   logic [47:0] lba;
   logic [15:0] count;
   logic        m_valid, m_last, m_unc, m_idnf, m_req, m_ready, w_valid, done, h_busy;
   logic [15:0] m_word, word;
   logic [7:0]  status, error;
   logic [47:0] err_lba, m_lba;
   logic [15:0] exp_q[$];
   int          n_mismatch, checks_done, sec_w, bad_sec, bad_kind, secs, wi, n_words;
   rdx_if link ();
   rdx_dev #(.DEV_POS(1'b0), .DEPTH(rdx_pkg::FIFO_DEPTH)) rdx_dev_inst (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .link(link),
      .o_media_req(m_req), .o_media_lba(m_lba), .o_media_ready(m_ready),
      .i_media_valid(m_valid), .i_media_word(m_word), .i_media_last(m_last),
      .i_media_unc(m_unc), .i_media_idnf(m_idnf));
   rdx_host rdx_host_inst (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .link(link),
      .i_start(start), .i_lba(lba), .i_count(count), .i_dev_sel(dev_sel),
      .o_word_valid(w_valid), .o_word(word), .o_done(done), .o_busy(h_busy),
      .o_status(status), .o_error(error), .o_err_lba(err_lba));
   rdx_props rdx_props_inst (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .wr(link.wr), .rd(link.rd),
      .addr(link.addr), .wdata(link.wdata), .dmack(link.dmack), .rdata(link.rdata),
      .rvalid(link.rvalid), .dmarq(link.dmarq), .data(link.data), .intrq(link.intrq));
   // 20 MHz reference clock
   initial
   begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // error byte expected for each fault kind of the media source
   function automatic logic [7:0] exp_error(input int bk);
      exp_error = 8'h00;
      if (bk == 1)
         exp_error[rdx_pkg::ERR_UNC] = 1'b1;
      else if (bk == 2)
         exp_error[rdx_pkg::ERR_IDN] = 1'b1;
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // media source; the bad sector is flagged on its words, which are dropped
   always @(posedge i_ref_clk)
   begin
      if (m_valid && m_ready)
      begin
         if (!(m_unc || m_idnf))
            exp_q.push_back(m_word);
         secs = secs + int'(m_last);
         wi = m_last ? 0 : wi + 1;
      end
      if (!m_valid || m_ready || !m_req)
      begin
         m_valid <= m_req;
         m_word  <= 16'($urandom);
         m_last  <= (wi == sec_w - 1);
         m_unc   <= (secs == bad_sec) && (bad_kind == 1);
         m_idnf  <= (secs == bad_sec) && (bad_kind == 2);
      end
   end
   // words reaching the host user side must follow the media order
   always @(posedge i_ref_clk)
      if (w_valid === 1'b1)
      begin
         n_words++;
         if (exp_q.size() == 0)
            chk(48'h1, 48'h0, "extra word");
         else
            chk(48'(word), 48'(exp_q.pop_front()), "word");
      end
   task automatic kick(input logic [47:0] a, input logic [15:0] c, input logic sel);
      exp_q.delete();
      secs = 0;
      wi = 0;
      n_words = 0;
      lba <= a;
      count <= c;
      dev_sel <= sel;
      start <= 1'b1;
      @(posedge i_ref_clk);
      start <= 1'b0;
   endtask
   task automatic run(input logic [47:0] a, input logic [15:0] c, input int sw, bs, bk);
      int k;
      int good;
      sec_w = sw;
      bad_sec = bs;
      bad_kind = bk;
      good = (bk == 0) ? int'(c) : bs;
      kick(a, c, 1'b0);
      k = 0;
      while (done !== 1'b1 && k < 20000)
      begin
         @(posedge i_ref_clk);
         k++;
      end
      chk(48'(done), 48'h1, "done");
      chk(48'(n_words), 48'(good * sw), "words");
      chk(48'(status), 48'(8'h50 | (bk != 0)), "status");
      chk(48'(error), 48'(exp_error(bk)), "error");
      chk(err_lba, a + 48'(good), "lba back");
      chk(m_lba, a + 48'(good), "media lba");
      chk(48'(h_busy), 48'h0, "host idle");
      $display("test end t=%0t lba %h count %h", $time, a, c);
   endtask
   task automatic reset_pulse();
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
   endtask
   // main sequence: corners, random reads, faults, ignored and huge commands
   initial
   begin
      int k;
      {i_resetn, start, dev_sel, lba, count} = '0;
      {m_valid, m_last, m_unc, m_idnf, m_word} = '0;
      {n_mismatch, checks_done, bad_sec, bad_kind, secs, wi, n_words} = '0;
      sec_w = 1;
      k = $urandom(39708);
      repeat (12) @(posedge i_ref_clk);
      reset_pulse();
      run(48'h00ff_ffff_ffff, 16'h0002, 2, 0, 0);
      run(48'hffff_ffff_ffff, 16'h0001, 3, 0, 0);
      run({16'($urandom), 32'($urandom)}, 16'h0101, 1, 0, 0);
      repeat (6)
         run({16'($urandom), 32'($urandom)}, 16'($urandom_range(4, 1)),
             $urandom_range(6, 1), 0, 0);
      run({16'($urandom), 32'($urandom)}, 16'h0003, 2, 1, 1);
      run({16'($urandom), 32'($urandom)}, 16'h0004, 1, 0, 2);
      // command for the other device position is left alone
      kick(48'h0, 16'h0001, 1'b1);
      repeat (100) @(posedge i_ref_clk);
      chk(48'(m_req), 48'h0, "media idle");
      chk(48'(link.intrq), 48'h0, "no irq");
      chk(48'(h_busy), 48'h1, "host still waits");
      $display("test end t=%0t other device position", $time);
      reset_pulse();
      // zero count keeps reading well past 256 sectors
      sec_w = 1;
      bad_kind = 0;
      kick(48'h10, 16'h0000, 1'b0);
      k = 0;
      while (secs < 300 && k < 5000)
      begin
         @(posedge i_ref_clk);
         k++;
      end
      chk(48'(m_req), 48'h1, "still reading");
      chk(48'(link.intrq), 48'h0, "no irq yet");
      $display("test end t=%0t zero count", $time);
      reset_pulse();
      run({16'($urandom), 32'($urandom)}, 16'h0002, 4, 0, 0);
      test_done();
   end
   // watchdog, far beyond the length of the whole sequence
   initial
   begin
      repeat (TMO) @(posedge i_ref_clk);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      test_done();
   end
endmodule
